// ---- hw/pot_tap_to_wiper_byte_encoder.sv ----
// Contract
// - Taps 75 to 99 encode as 195 minus the tap.
// - Taps 50 to 74 encode as the tap plus 14.
// - Taps 25 to 49 encode as 81 minus the tap.
// - Taps 0 to 24 encode as the tap itself.
// - The stored wiper setting returns 0.7 to 1.3 us after the supply passes its threshold; the default delay is RECALL_TYP_CYC, 250 cycles of 4000 ps, or 1 us.
`timescale 1ns/1ps
module pot_tap_to_wiper_byte_encoder
   import tap_encoder_pkg::*;
#(
   parameter int unsigned RECALL_DELAY_CYC = RECALL_TYP_CYC
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic [TAP_WIDTH-1:0]  tap_position,
   input  wire logic                  recall_supply_threshold,
   input  wire logic [BYTE_WIDTH-1:0] stored_wiper_byte,
   output logic      [BYTE_WIDTH-1:0] wiper_byte,
   output logic      [BYTE_WIDTH-1:0] hundred_tap_potentiometer,
   output logic                       recall_done
);

   logic [BYTE_WIDTH-1:0]   code;
   logic [BYTE_WIDTH-1:0]   tap_ext;
   logic [BYTE_WIDTH-1:0]   wiper_byte_reg;
   logic [BYTE_WIDTH-1:0]   wiper_byte_next;

   // An unsigned input cannot be negative, so only the high clamp is reachable.
   always_comb begin
      tap_ext = {1'b0, tap_position};
      if (tap_position > TAP_MAX) begin
         code = CLAMP_HIGH_BYTE;
      end else if (tap_position >= SEG3_FIRST) begin
         code = SEG3_BASE - tap_ext;
      end else if (tap_position >= SEG2_FIRST) begin
         code = tap_ext + SEG2_OFFSET;
      end else if (tap_position >= SEG1_FIRST) begin
         code = SEG1_BASE - tap_ext;
      end else begin
         code = tap_ext;
      end
      wiper_byte_next = code;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wiper_byte_reg <= 8'h00;
      end else begin
         wiper_byte_reg <= wiper_byte_next;
      end
   end

   assign wiper_byte = wiper_byte_reg;

   // Power-up recall: wait a fixed delay after the supply rises, then load the wiper once.
   recall_state_t           state_reg;
   recall_state_t           state_next;
   logic [RECALL_CNT_W-1:0] count_reg;
   logic [RECALL_CNT_W-1:0] count_next;
   logic [BYTE_WIDTH-1:0]   pot_reg;
   logic [BYTE_WIDTH-1:0]   pot_next;
   logic                    done_reg;
   logic                    done_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      pot_next   = pot_reg;
      done_next  = done_reg;
      case (state_reg)
         RECALL_IDLE: begin
            if (recall_supply_threshold) begin
               state_next = RECALL_WAIT;
               count_next = RECALL_CNT_W'(1);
            end
         end
         RECALL_WAIT: begin
            if (!recall_supply_threshold) begin
               // A supply dip restarts the whole delay.
               state_next = RECALL_IDLE;
               count_next = '0;
            end else if (count_reg >= RECALL_CNT_W'(RECALL_DELAY_CYC - 1)) begin
               state_next = RECALL_DONE;
               pot_next   = stored_wiper_byte;
               done_next  = 1'b1;
            end else begin
               count_next = count_reg + RECALL_CNT_W'(1);
            end
         end
         RECALL_DONE: begin
            if (!recall_supply_threshold) begin
               state_next = RECALL_IDLE;
               count_next = '0;
               done_next  = 1'b0;
            end
         end
         default: begin
            state_next = RECALL_IDLE;
            count_next = '0;
            done_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= RECALL_IDLE;
         count_reg <= '0;
         pot_reg   <= 8'h00;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         pot_reg   <= pot_next;
         done_reg  <= done_next;
      end
   end

   assign hundred_tap_potentiometer = pot_reg;
   assign recall_done               = done_reg;

endmodule // pot_tap_to_wiper_byte_encoder

// ---- hw/tap_encoder_pkg.sv ----
package tap_encoder_pkg;

   localparam int unsigned TAP_WIDTH       = 7;
   localparam int unsigned BYTE_WIDTH      = 8;
   localparam logic [6:0]  TAP_MAX         = 7'h63;
   localparam logic [6:0]  SEG1_FIRST      = 7'h19;
   localparam logic [6:0]  SEG2_FIRST      = 7'h32;
   localparam logic [6:0]  SEG3_FIRST      = 7'h4B;
   localparam logic [7:0]  SEG1_BASE       = 8'h51;
   localparam logic [7:0]  SEG2_OFFSET     = 8'h0E;
   localparam logic [7:0]  SEG3_BASE       = 8'hC3;
   localparam logic [7:0]  CLAMP_HIGH_BYTE = 8'h60;

   // Recall delay limits, in nanoseconds (times 1000 gives picoseconds), and the clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS   = 4000;
   localparam int unsigned RECALL_MIN_US   = 700;
   localparam int unsigned RECALL_TYP_US   = 1000;
   localparam int unsigned RECALL_MAX_US   = 1300;
   localparam int unsigned RECALL_MIN_CYC  = (RECALL_MIN_US * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned RECALL_TYP_CYC  = (RECALL_TYP_US * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RECALL_MAX_CYC  = (RECALL_MAX_US * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RECALL_CNT_W    = 20;

   typedef enum logic [1:0] {
      RECALL_IDLE,
      RECALL_WAIT,
      RECALL_DONE
   } recall_state_t;

endpackage

// ---- tb/tap_enc_sva.sv ----
`timescale 1ns/1ps
module tap_enc_sva (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [6:0] tap_position,
   input wire logic       recall_supply_threshold,
   input wire logic [7:0] stored_wiper_byte,
   input wire logic [7:0] wiper_byte,
   input wire logic [7:0] hundred_tap_potentiometer,
   input wire logic       recall_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_seg_low: assert property (!$past(rst) && $past(tap_position) < 25
      |-> wiper_byte == $past(tap_position)) else $error("low segment");
   a_seg_fall: assert property (!$past(rst) && $past(tap_position) inside {[25:49]}
      |-> wiper_byte == 81 - $past(tap_position)) else $error("second segment");
   a_seg_rise: assert property (!$past(rst) && $past(tap_position) inside {[50:74]}
      |-> wiper_byte == $past(tap_position) + 14) else $error("third segment");
   a_seg_top: assert property (!$past(rst) && $past(tap_position) inside {[75:99]}
      |-> wiper_byte == 195 - $past(tap_position)) else $error("top segment");
   a_clamp_high: assert property (!$past(rst) && $past(tap_position) > 99
      |-> wiper_byte == 8'h60) else $error("clamp");
   a_recall_wait: assert property ($rose(recall_supply_threshold)
      ##1 recall_supply_threshold [*7] |-> ##[1:2] recall_done
      && hundred_tap_potentiometer == stored_wiper_byte) else $error("recall");
   a_done_drop: assert property (recall_done && !recall_supply_threshold
      |=> !recall_done) else $error("recall done not cleared");
   a_pot_only_recall: assert property ($changed(hundred_tap_potentiometer)
      |-> $rose(recall_done)) else $error("pot changed outside recall");
endmodule // tap_enc_sva
bind pot_tap_to_wiper_byte_encoder tap_enc_sva u_tap_enc_sva (.*);

// ---- tb/tap_host.sv ----
`timescale 1ns/1ps
module tap_host (
   input  wire logic [6:0] want,
   output logic      [6:0] tap_position
);
   assign tap_position = want;
endmodule // tap_host

// ---- tb/pot_tap_to_wiper_byte_encoder_test.sv ----
`timescale 1ns/1ps
module pot_tap_to_wiper_byte_encoder_test;
   logic       mclk = 0, rst = 1, thr = 0, done;
   logic [6:0] want = 0, tap;
   logic [7:0] stored = 8'h00, wb, pot;
   logic [7:0] q[$];
   int         n_errors = 0, comparisons = 0, cyc = 0;
   initial forever #2 mclk = ~mclk;
   tap_host u_tap_host (.want(want), .tap_position(tap));
   pot_tap_to_wiper_byte_encoder #(.RECALL_DELAY_CYC(8)) u_pot_tap_to_wiper_byte_encoder (
      .mclk(mclk), .rst(rst), .tap_position(tap), .recall_supply_threshold(thr),
      .stored_wiper_byte(stored), .wiper_byte(wb), .hundred_tap_potentiometer(pot),
      .recall_done(done));
   function automatic logic [7:0] enc(int t);
      return t > 99 ? 8'h60 : t > 74 ? 8'(195 - t) : t > 49 ? 8'(t + 14) :
             t > 24 ? 8'(81 - t) : 8'(t);
   endfunction
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic put(int t);
      @(posedge mclk) #1 want = 7'(t);
      q.push_back(enc(t));
   endtask
   // The monitor samples before the driver's next change, so each note meets its own result.
   always @(posedge mclk) begin
      #0.5 if (q.size() > 0) check("wiper_byte", wb, q.pop_front());
      if (++cyc > 2000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      void'($urandom(67));
      repeat (6) @(posedge mclk);
      #1 rst = 0;
      for (int t = 0; t < 128; t++) put(t);
      repeat (40) put($urandom_range(99));
      stored = 8'($urandom_range(255, 1));
      @(posedge mclk) #1 thr = 1;
      repeat (4) @(posedge mclk);
      #1 thr = 0;
      @(posedge mclk) #1 thr = 1;
      repeat (7) @(posedge mclk);
      #1 check("recall_done", {7'h00, done}, 8'h00);
      check("pot", pot, 8'h00);
      @(posedge mclk) #1 check("recall_done", {7'h00, done}, 8'h01);
      check("pot", pot, stored);
      thr = 0;
      @(posedge mclk) #1 check("recall_done", {7'h00, done}, 8'h00);
      check("pot", pot, stored);
      summarize();
   end
endmodule // pot_tap_to_wiper_byte_encoder_test
